//--- shared/usbhf_pkg.sv
// package of constants and carrier types for the usb host event flag block
package usbhf_pkg;

  // ****************************************
  // register map, byte addresses of word registers
  // ****************************************
  localparam logic [7:0] ADDR_FLAGS = 8'h00;  // event flags, write one to clear
  localparam logic [7:0] ADDR_ENABLE = 8'h04;  // interrupt enable mask
  localparam logic [7:0] ADDR_CTRL = 8'h08;  // host mode, speed, bus reset
  localparam logic [7:0] ADDR_SOF_THR = 8'h0C;  // frame start threshold
  localparam logic [7:0] ADDR_ERR_EN = 8'h10;  // error source enables
  localparam logic [7:0] ADDR_TOK_STAT = 8'h14;  // token status snapshot

  // ****************************************
  // field layout of the flag and enable words
  // ****************************************
  localparam int BIT_STALL = 7;
  localparam int BIT_ATTACH = 6;
  localparam int BIT_RESUME = 5;
  localparam int BIT_IDLE = 4;
  localparam int BIT_TOKEN = 3;
  localparam int BIT_SOF = 2;
  localparam int BIT_ERROR = 1;
  localparam int BIT_DETACH = 0;
  localparam int FLAG_W = 8;  // implemented flags, bits 15-8 read zero
  localparam int WORD_W = 16;

  // control word fields
  localparam int CTRL_HOST = 0;
  localparam int CTRL_LOW_SPEED = 1;
  localparam int CTRL_BUS_RESET = 2;
  localparam int CTRL_W = 3;

  // other widths
  localparam int ERR_W = 8;
  localparam int FRAME_W = 14;
  localparam int TOK_W = 8;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [FLAG_W-1:0] FLAGS_RST = 8'h00;
  localparam logic [FLAG_W-1:0] ENABLE_RST = 8'h00;
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
  localparam logic [FRAME_W-1:0] SOF_THR_RST = 14'h0000;
  localparam logic [ERR_W-1:0] ERR_EN_RST = 8'h00;
  localparam logic [TOK_W-1:0] TOK_RST = 8'h00;

  // ****************************************
  // timing
  // ****************************************
  localparam longint CLK_PERIOD_PS = 5000;  // 200 mhz core clock
  localparam longint LINE_TIME_NS = 2500;  // attach, resume, detach persistence
  localparam longint IDLE_TIME_NS = 3000000;  // idle persistence, 3 ms
  // least times round up to whole cycles
  localparam int LINE_CYCLES = int'((LINE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int IDLE_CYCLES = int'((IDLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int TIMER_W = 20;  // wide enough for the idle count

  // ****************************************
  // carriers
  // ****************************************
  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [WORD_W-1:0] wdata;
    logic wr;
    logic rd;
  } usbhf_req_t;

  // same-clock events from the transfer engine
  typedef struct packed {
    logic stall_hs;  // stall handshake seen in handshake phase
    logic token_done;  // current token processing finished
    logic [TOK_W-1:0] token_info;  // endpoint details for that token
    logic [ERR_W-1:0] err_src;  // error source pulses
    logic [FRAME_W-1:0] frame_timer;  // running frame timer
  } usbhf_evt_t;

endpackage

//--- hdl/usbhf_persist.sv
// persistence timer: one pulse once a condition has held for a set count
`timescale 1ns/1ps
`default_nettype none
module usbhf_persist
  import usbhf_pkg::*;
#(
  parameter int CYCLES = LINE_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // condition in, pulse out
  input wire logic cond,
  output logic hit
);

  // ****************************************
  // counter
  // ****************************************
  localparam logic [TIMER_W-1:0] LAST = TIMER_W'(CYCLES - 1);

  logic [TIMER_W-1:0] cnt_r;  // cycles the condition has held
  logic [TIMER_W-1:0] cnt_nxt;
  logic done_r;  // count reached, holds until condition drops
  logic done_nxt;
  logic reach;

  // reach when the last cycle of the run is seen
  assign reach = cond && !done_r && (cnt_r == LAST);
  // restart on any break of the condition
  assign cnt_nxt = !cond ? '0 : (done_r || reach) ? cnt_r : cnt_r + 1'b1;
  assign done_nxt = cond && (done_r || reach);
  // single pulse per unbroken run
  assign hit = reach;

  // counter and done flop
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= '0;
      done_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

endmodule
`default_nettype wire

//--- hdl/usbhf_core.sv
// host event flag register with bus line detectors and interrupt output
//
// Notes on behaviour
// RULE1: upper status byte reads zero, ignores writes
// RULE2: flags set only by hardware, reset zero
// RULE3: stall handshake sets bit 7
// RULE4: non-SE0, quiet 2.5 us sets attach bit 6
// RULE5: K-state held 2.5 us sets resume bit 5
// RULE6: idle held 3 ms sets bit 4
// RULE7: token finish sets bit 3, status captured
// RULE8: software then clears or fetches token status
// RULE9: host frame timer at threshold sets bit 2
// RULE10: only enabled error sources set bit 1
// RULE11: detach sets bit 0, rearms after reset cleared
// RULE12: word write of ones clears those flags
// RULE13: software clears with full-word one masks only; the code clears each flag whose bit is one in any written mask
// RULE14: interrupt only for set and enabled flags
// RULE15: hardware set beats same-cycle software clear
`timescale 1ns/1ps
`default_nettype none
module usbhf_core
  import usbhf_pkg::*;
#(
  parameter int IDLE_CNT = IDLE_CYCLES  // shorten for simulation
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // register port
  input wire usbhf_req_t req,
  output logic [WORD_W-1:0] rd_data,
  // bus data line pins, asynchronous
  input wire logic dp_pin,
  input wire logic dm_pin,
  // transfer engine events, same clock
  input wire usbhf_evt_t evt,
  // control levels to the rest of the controller
  output logic host_mode,
  output logic low_speed,
  output logic bus_reset,
  // interrupt request, level
  output logic irq
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] pin_raw;  // dp in bit 1, dm in bit 0
  logic [1:0] pin_s1_r;  // first stage, read only by second
  logic [1:0] pin_s2_r;  // stable samples

  assign pin_raw = {dp_pin, dm_pin};

  // two flip-flops per line
  generate
    for (genvar i = 0; i < 2; i++) begin : g_sync
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          pin_s1_r[i] <= 1'b0;
          pin_s2_r[i] <= 1'b0;
        end else begin
          pin_s1_r[i] <= pin_raw[i];
          pin_s2_r[i] <= pin_s1_r[i];
        end
      end
    end
  endgenerate

  // ****************************************
  // register decode
  // ****************************************
  logic wr_flags;
  logic wr_enable;
  logic wr_ctrl;
  logic wr_thr;
  logic wr_err_en;
  logic rd_flags;

  assign wr_flags = req.wr && (req.addr == ADDR_FLAGS);
  assign wr_enable = req.wr && (req.addr == ADDR_ENABLE);
  assign wr_ctrl = req.wr && (req.addr == ADDR_CTRL);
  assign wr_thr = req.wr && (req.addr == ADDR_SOF_THR);
  assign wr_err_en = req.wr && (req.addr == ADDR_ERR_EN);
  assign rd_flags = req.rd && (req.addr == ADDR_FLAGS);

  // ****************************************
  // software registers
  // ****************************************
  logic [FLAG_W-1:0] enable_r;  // interrupt enable mask
  logic [CTRL_W-1:0] ctrl_r;  // control levels
  logic [FRAME_W-1:0] sof_thr_r;  // frame start threshold
  logic [ERR_W-1:0] err_en_r;  // error source enables
  logic [TOK_W-1:0] tok_stat_r;  // token status snapshot

  // plain read/write registers, only low bits stored
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      enable_r <= ENABLE_RST;
      ctrl_r <= CTRL_RST;
      sof_thr_r <= SOF_THR_RST;
      err_en_r <= ERR_EN_RST;
    end else begin
      if (wr_enable) begin
        enable_r <= req.wdata[FLAG_W-1:0];
      end
      if (wr_ctrl) begin
        ctrl_r <= req.wdata[CTRL_W-1:0];
      end
      if (wr_thr) begin
        sof_thr_r <= req.wdata[FRAME_W-1:0];
      end
      if (wr_err_en) begin
        err_en_r <= req.wdata[ERR_W-1:0];
      end
    end
  end

  assign host_mode = ctrl_r[CTRL_HOST];
  assign low_speed = ctrl_r[CTRL_LOW_SPEED];
  assign bus_reset = ctrl_r[CTRL_BUS_RESET];

  // ****************************************
  // line state decode
  // ****************************************
  logic line_dp;
  logic line_dm;
  logic se0;  // both lines low
  logic j_state;  // idle polarity for the current speed
  logic k_state;  // resume polarity for the current speed
  logic [1:0] line_prev_r;  // last sample, for activity detection
  logic activity;  // any change of line state

  assign line_dp = pin_s2_r[1];
  assign line_dm = pin_s2_r[0];
  assign se0 = !line_dp && !line_dm;
  // full speed: j is differential one, k differential zero
  // low speed: polarity swaps
  assign j_state = low_speed ? (line_dm && !line_dp) : (line_dp && !line_dm);
  assign k_state = low_speed ? (line_dp && !line_dm) : (line_dm && !line_dp);  // see RULE5
  assign activity = (pin_s2_r != line_prev_r);

  // previous sample of the synchronised lines
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      line_prev_r <= 2'h0;
    end else begin
      line_prev_r <= pin_s2_r;
    end
  end

  // ****************************************
  // persistence detectors
  // ****************************************
  logic attach_cond;
  logic resume_cond;
  logic idle_cond;
  logic detach_cond;
  logic attach_hit;
  logic resume_hit;
  logic idle_hit;
  logic detach_hit;

  // quiet, non-SE0 line means a peripheral pulled a line up
  assign attach_cond = host_mode && !se0 && !activity;  // see RULE4
  assign resume_cond = host_mode && k_state && !activity;  // see RULE5
  assign idle_cond = j_state && !activity;  // see RULE6
  // SE0 held by the host side pull-downs means the peripheral is gone
  assign detach_cond = host_mode && se0 && !bus_reset;  // see RULE11

  // attach timer
  usbhf_persist #(
    .CYCLES(LINE_CYCLES)
  ) u_attach (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .cond(attach_cond),
    .hit(attach_hit)
  );

  // resume timer
  usbhf_persist #(
    .CYCLES(LINE_CYCLES)
  ) u_resume (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .cond(resume_cond),
    .hit(resume_hit)
  );

  // idle timer, long count is a parameter
  usbhf_persist #(
    .CYCLES(IDLE_CNT)
  ) u_idle (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .cond(idle_cond),
    .hit(idle_hit)
  );

  // detach timer
  usbhf_persist #(
    .CYCLES(LINE_CYCLES)
  ) u_detach (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .cond(detach_cond),
    .hit(detach_hit)
  );

  // ****************************************
  // detach rearm sequencer
  // ****************************************
  typedef enum logic [2:0] {
    DET_ARMED = 3'b001,  // may report a detach
    DET_FIRED = 3'b010,  // reported, wait for bus reset
    DET_RESET = 3'b100   // bus reset on, wait for its release
  } usbhf_det_t;

  usbhf_det_t det_r;
  usbhf_det_t det_nxt;
  logic detach_set;

  // only an armed sequencer passes a detach to the flag
  assign detach_set = detach_hit && (det_r == DET_ARMED);  // see RULE11

  // next state of the rearm sequencer
  always_comb begin
    det_nxt = det_r;
    case (det_r)
      DET_ARMED: begin
        if (detach_set) begin
          det_nxt = DET_FIRED;
        end
      end
      DET_FIRED: begin
        if (bus_reset) begin
          det_nxt = DET_RESET;
        end
      end
      DET_RESET: begin
        // rearm only once reset state is cleared
        if (!bus_reset) begin
          det_nxt = DET_ARMED;  // see RULE11
        end
      end
      default: begin
        det_nxt = DET_ARMED;
      end
    endcase
  end

  // sequencer state
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      det_r <= DET_ARMED;
    end else begin
      det_r <= det_nxt;
    end
  end

  // ****************************************
  // frame start threshold
  // ****************************************
  logic sof_match;
  logic sof_match_r;  // last match, so a stalled timer sets once
  logic sof_set;

  assign sof_match = (evt.frame_timer == sof_thr_r);
  assign sof_set = host_mode && sof_match && !sof_match_r;  // see RULE9

  // match history
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sof_match_r <= 1'b0;
    end else begin
      sof_match_r <= sof_match;
    end
  end

  // ****************************************
  // token status capture
  // ****************************************
  // endpoint details stand ready when the flag rises
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tok_stat_r <= TOK_RST;
    end else if (evt.token_done) begin
      tok_stat_r <= evt.token_info;  // see RULE7
    end
  end

  // ****************************************
  // event flags
  // ****************************************
  logic [FLAG_W-1:0] flags_r;
  logic [FLAG_W-1:0] flags_nxt;
  logic [FLAG_W-1:0] hw_set;  // this cycle's hardware events
  logic [FLAG_W-1:0] sw_clr;  // this cycle's write-one-to-clear mask
  logic err_set;

  // masked error summary
  assign err_set = |(evt.err_src & err_en_r);  // see RULE10

  // gather the events into flag positions
  always_comb begin
    hw_set = '0;
    hw_set[BIT_STALL] = evt.stall_hs;  // see RULE3
    hw_set[BIT_ATTACH] = attach_hit;  // see RULE4
    hw_set[BIT_RESUME] = resume_hit;  // see RULE5
    hw_set[BIT_IDLE] = idle_hit;  // see RULE6
    hw_set[BIT_TOKEN] = evt.token_done;  // see RULE7
    hw_set[BIT_SOF] = sof_set;  // see RULE9
    hw_set[BIT_ERROR] = err_set;  // see RULE10
    hw_set[BIT_DETACH] = detach_set;  // see RULE11
  end

  // only the low byte is cleared, writes above it are dropped
  assign sw_clr = wr_flags ? req.wdata[FLAG_W-1:0] : '0;  // see RULE1, see RULE12
  // a set in the clearing cycle survives
  assign flags_nxt = (flags_r & ~sw_clr) | hw_set;  // see RULE15, see RULE2

  // flag storage, all clear at reset
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_r <= FLAGS_RST;  // see RULE2
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // ****************************************
  // interrupt
  // ****************************************
  // level while any enabled flag is set
  assign irq = |(flags_r & enable_r);  // see RULE14

  // ****************************************
  // read path
  // ****************************************
  logic [WORD_W-1:0] rd_mux;
  logic [WORD_W-1:0] rd_data_r;

  // select the addressed word, upper bits zero
  always_comb begin
    rd_mux = '0;
    case (req.addr)
      ADDR_FLAGS: begin
        rd_mux = {{(WORD_W - FLAG_W){1'b0}}, flags_r};  // see RULE1
      end
      ADDR_ENABLE: begin
        rd_mux = {{(WORD_W - FLAG_W){1'b0}}, enable_r};
      end
      ADDR_CTRL: begin
        rd_mux = {{(WORD_W - CTRL_W){1'b0}}, ctrl_r};
      end
      ADDR_SOF_THR: begin
        rd_mux = {{(WORD_W - FRAME_W){1'b0}}, sof_thr_r};
      end
      ADDR_ERR_EN: begin
        rd_mux = {{(WORD_W - ERR_W){1'b0}}, err_en_r};
      end
      ADDR_TOK_STAT: begin
        rd_mux = {{(WORD_W - TOK_W){1'b0}}, tok_stat_r};
      end
      default: begin
        rd_mux = '0;  // unmapped reads zero
      end
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_r <= '0;
    end else if (req.rd) begin
      rd_data_r <= rd_mux;
    end else begin
      rd_data_r <= '0;
    end
  end

  assign rd_data = rd_data_r;

  // flag reads have no side effect; software clears by writing ones
  logic unused_rd_flags;
  assign unused_rd_flags = rd_flags;

endmodule
`default_nettype wire

//--- verif/usbhf_core_asserts.sv
// concurrent checks on the ports of the usb host event flag block
`timescale 1ns/1ps
`default_nettype none
module usbhf_core_asserts
  import usbhf_pkg::*;
#(
  parameter int IDLE_CNT = IDLE_CYCLES  // idle persistence count, as the design
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // register port
  input wire usbhf_req_t req,
  input wire logic [WORD_W-1:0] rd_data,
  // bus lines and engine events
  input wire logic dp_pin,
  input wire logic dm_pin,
  input wire usbhf_evt_t evt,
  // control levels and interrupt
  input wire logic host_mode,
  input wire logic low_speed,
  input wire logic bus_reset,
  input wire logic irq
);
  // ****************************************
  // checks, all in the core clock domain
  // ****************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  // read data only in the cycle after a read strobe
  chk_rd_data_idle: assert property (!$past(req.rd) |-> rd_data == 16'h0000)
    else $error("read data not zero outside a read answer");
  // upper byte of the flag word always reads zero
  chk_upper_byte_zero: assert property ($past(req.rd) && $past(req.addr) == ADDR_FLAGS
    |-> rd_data[15:8] == 8'h00)
    else $error("upper flag byte not zero");
  // stall handshake shows in the flags a cycle later
  chk_stall_flag_set: assert property (evt.stall_hs ##1 (req.rd && req.addr == ADDR_FLAGS)
    |=> rd_data[BIT_STALL])
    else $error("stall flag not set after handshake");
  // token finish captures its endpoint details
  chk_token_status_held: assert property (evt.token_done ##1 (req.rd && req.addr == ADDR_TOK_STAT)
    |=> rd_data == {8'h00, $past(evt.token_info, 2)})
    else $error("token status differs from captured details");
  // the interrupt only drops after a register write
  chk_irq_fall_cause: assert property ($fell(irq) |-> $past(req.wr))
    else $error("interrupt fell without a write");
  // control levels follow a control write
  chk_ctrl_levels: assert property (req.wr && req.addr == ADDR_CTRL |=>
    host_mode == $past(req.wdata[CTRL_HOST]) && bus_reset == $past(req.wdata[CTRL_BUS_RESET])
    && low_speed == $past(req.wdata[CTRL_LOW_SPEED]))
    else $error("control levels do not follow the write");
  // a one written clears the flag when no event competes
  chk_clear_one: assert property ((req.wr && req.addr == ADDR_FLAGS && req.wdata[BIT_STALL]
    && !evt.stall_hs) ##1 (req.rd && req.addr == ADDR_FLAGS && !evt.stall_hs)
    |=> !rd_data[BIT_STALL])
    else $error("stall flag survived a clear");
  // a same-cycle event beats the clear
  chk_set_beats_clear: assert property ((req.wr && req.addr == ADDR_FLAGS
    && req.wdata[BIT_STALL] && evt.stall_hs) ##1 (req.rd && req.addr == ADDR_FLAGS)
    |=> rd_data[BIT_STALL])
    else $error("stall event lost to a clear");
endmodule
bind usbhf_core usbhf_core_asserts #(.IDLE_CNT(IDLE_CNT)) u_usbhf_core_asserts (
  .core_clk(core_clk), .reset_n(reset_n), .req(req), .rd_data(rd_data), .dp_pin(dp_pin),
  .dm_pin(dm_pin), .evt(evt), .host_mode(host_mode), .low_speed(low_speed),
  .bus_reset(bus_reset), .irq(irq));
`default_nettype wire

//--- verif/usbhf_periph_model.sv
// model of the attached peripheral: drives the bus line states
`timescale 1ns/1ps
`default_nettype none
module usbhf_periph_model (
  // line state asked for: 0 se0, 1 j, 2 k
  input wire logic [1:0] line_state,
  input wire logic low_speed,
  // bus data lines
  output logic dp_pin,
  output logic dm_pin
);
  // ****************************************
  // line drive
  // ****************************************
  // detached or se0 leaves both lines at the host pull-down level
  // low speed swaps j and k against full speed
  assign dp_pin = (line_state == 2'h1) ? !low_speed : (line_state == 2'h2) ? low_speed : 1'b0;
  assign dm_pin = (line_state == 2'h1) ? low_speed : (line_state == 2'h2) ? !low_speed : 1'b0;
endmodule
`default_nettype wire

//--- verif/testbench.sv
// self-checking bench for the usb host event flag block
`timescale 1ns/1ps
`default_nettype none
module testbench
  import usbhf_pkg::*;
;
  // ****************************************
  // signals
  // ****************************************
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  usbhf_req_t req = '0;
  usbhf_evt_t evt = '0;
  logic [1:0] line_state = 2'h0;  // peripheral starts detached
  logic [WORD_W-1:0] rd_data;
  logic dp_pin, dm_pin, host_mode, low_speed, bus_reset, irq;
  int n_fail = 0;
  int checked = 0;
  // register rows: address, write value, readback expected
  logic [7:0] r_addr [7] = '{ADDR_ENABLE, ADDR_SOF_THR, ADDR_ERR_EN, ADDR_TOK_STAT,
    ADDR_FLAGS, ADDR_CTRL, 8'h20};
  logic [15:0] r_wd [7] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0000,
    16'hFFFF};
  logic [15:0] r_exp [7] = '{16'h00FF, 16'h3FFF, 16'h00FF, 16'h0000, 16'h0000, 16'h0000,
    16'h0000};

  // ****************************************
  // design and partner
  // ****************************************
  usbhf_core #(.IDLE_CNT(20)) u_usbhf_core (.core_clk(core_clk), .reset_n(reset_n),
    .req(req), .rd_data(rd_data), .dp_pin(dp_pin), .dm_pin(dm_pin), .evt(evt),
    .host_mode(host_mode), .low_speed(low_speed), .bus_reset(bus_reset), .irq(irq));
  usbhf_periph_model u_usbhf_periph_model (.line_state(line_state), .low_speed(low_speed),
    .dp_pin(dp_pin), .dm_pin(dm_pin));

  // 200 mhz clock
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end

  // ****************************************
  // tasks
  // ****************************************
  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // print counts and verdict, then stop
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // events and optional write in one cycle, then a read, checked
  task automatic xfer(input logic st, input logic tk, input logic [7:0] er, input logic wr,
    input logic [7:0] wa, input logic [15:0] wd, input logic [7:0] ra, input logic [15:0] exp);
    @(posedge core_clk);
    evt.stall_hs <= st;
    evt.token_done <= tk;
    evt.err_src <= er;
    req <= '{addr: wa, wdata: wd, wr: wr, rd: 1'b0};
    @(posedge core_clk);
    evt.stall_hs <= 1'b0;
    evt.token_done <= 1'b0;
    evt.err_src <= 8'h00;
    req <= '{addr: ra, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    req.rd <= 1'b0;
    #1;
    check(rd_data, exp);
  endtask
  // hold a line state past the persistence count, then read flags and clear them
  task automatic line_run(input logic [1:0] st, input logic [15:0] exp);
    line_state <= st;
    repeat (520) @(posedge core_clk);
    xfer(0, 0, 8'h00, 0, 8'h00, 16'h0000, ADDR_FLAGS, exp);
    xfer(0, 0, 8'h00, 1, ADDR_FLAGS, 16'hFFFF, ADDR_FLAGS, 16'h0000);
  endtask

  // ****************************************
  // watchdog
  // ****************************************
  initial begin
    #200us;
    n_fail++;
    give_verdict();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    evt.token_info <= 8'hA5;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    // reset values, then write and read back each register
    for (int i = 0; i < 7; i++) begin
      xfer(0, 0, 8'h00, 0, 8'h00, 16'h0000, r_addr[i], 16'h0000);
      xfer(0, 0, 8'h00, 1, r_addr[i], r_wd[i], r_addr[i], r_exp[i]);
    end
    $display("test registers done");
    // stall sets, zero write keeps, one write clears
    xfer(1, 0, 8'h00, 0, 8'h00, 16'h0000, ADDR_FLAGS, 16'h0080);
    check({15'h0000, irq}, 16'h0001);
    xfer(0, 0, 8'h00, 1, ADDR_FLAGS, 16'hFF7F, ADDR_FLAGS, 16'h0080);
    xfer(0, 0, 8'h00, 1, ADDR_FLAGS, 16'h0080, ADDR_FLAGS, 16'h0000);
    check({15'h0000, irq}, 16'h0000);
    // event and clear together, event wins
    xfer(1, 0, 8'h00, 1, ADDR_FLAGS, 16'h0080, ADDR_FLAGS, 16'h0080);
    // mask the stall enable, interrupt drops while the flag stays
    xfer(0, 0, 8'h00, 1, ADDR_ENABLE, 16'h007F, ADDR_FLAGS, 16'h0080);
    check({15'h0000, irq}, 16'h0000);
    xfer(0, 0, 8'h00, 1, ADDR_FLAGS, 16'hFFFF, ADDR_ENABLE, 16'h007F);
    $display("test stall and mask done");
    // token finish captures details
    xfer(0, 1, 8'h00, 0, 8'h00, 16'h0000, ADDR_TOK_STAT, 16'h00A5);
    xfer(0, 0, 8'h00, 1, ADDR_ENABLE, 16'h00FF, ADDR_FLAGS, 16'h0008);
    check({15'h0000, irq}, 16'h0001);
    xfer(0, 0, 8'h00, 1, ADDR_FLAGS, 16'hFFFF, ADDR_FLAGS, 16'h0000);
    // error summary only from enabled sources
    xfer(0, 0, 8'h00, 1, ADDR_ERR_EN, 16'h0002, ADDR_FLAGS, 16'h0000);
    xfer(0, 0, 8'h01, 0, 8'h00, 16'h0000, ADDR_FLAGS, 16'h0000);
    xfer(0, 0, 8'h02, 1, ADDR_SOF_THR, 16'h0005, ADDR_FLAGS, 16'h0002);
    xfer(0, 0, 8'h00, 1, ADDR_FLAGS, 16'hFFFF, ADDR_FLAGS, 16'h0000);
    $display("test token and error done");
    // frame start at the threshold, host mode only
    evt.frame_timer <= 14'h0005;
    xfer(0, 0, 8'h00, 0, 8'h00, 16'h0000, ADDR_FLAGS, 16'h0000);
    evt.frame_timer <= 14'h0000;
    xfer(0, 0, 8'h00, 1, ADDR_CTRL, 16'h0001, ADDR_CTRL, 16'h0001);
    evt.frame_timer <= 14'h0005;
    xfer(0, 0, 8'h00, 0, 8'h00, 16'h0000, ADDR_FLAGS, 16'h0004);
    xfer(0, 0, 8'h00, 1, ADDR_FLAGS, 16'hFFFF, ADDR_FLAGS, 16'h0000);
    $display("test frame start done");
    // line detectors: detach, attach with idle, resume with a new attach, blocked detach
    line_run(2'h0, 16'h0001);
    line_run(2'h1, 16'h0050);
    line_run(2'h2, 16'h0060);
    line_run(2'h0, 16'h0000);
    // bus reset pulse rearms detach
    xfer(0, 0, 8'h00, 1, ADDR_CTRL, 16'h0005, ADDR_CTRL, 16'h0005);
    xfer(0, 0, 8'h00, 1, ADDR_CTRL, 16'h0001, ADDR_CTRL, 16'h0001);
    line_run(2'h0, 16'h0001);
    // low speed swaps the j and k polarities
    xfer(0, 0, 8'h00, 1, ADDR_CTRL, 16'h0003, ADDR_CTRL, 16'h0003);
    line_run(2'h2, 16'h0060);
    line_run(2'h1, 16'h0050);
    $display("test line detectors done");
    // a reset in mid-run clears a set flag
    xfer(1, 0, 8'h00, 0, 8'h00, 16'h0000, ADDR_FLAGS, 16'h0080);
    check({15'h0000, irq}, 16'h0001);
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    xfer(0, 0, 8'h00, 0, 8'h00, 16'h0000, ADDR_FLAGS, 16'h0000);
    check({15'h0000, irq}, 16'h0000);
    $display("test mid-run reset done");
    give_verdict();
  end
endmodule
`default_nettype wire
